// File: common/bldc_defs.vh
// constants for the sine-wave commutation block: offsets, fields, counts
// assumes the including file sits in a 200 MHz single-clock design
//
// What this block does
// RULE1 - square drive until threshold, then sine drive
// RULE2 - above threshold, hall position feeds modulated wave
// RULE3 - speed command low turns all outputs off
// RULE4 - wave amplitude scales with speed command
// RULE5 - triangle carrier is clock divided by 252
// RULE6 - lead angle 0..29 degrees in 32 steps; the code drops the input LSB: 16 steps of 1.875, 0..28.1 degrees
// RULE7 - lead angle only applied during sine drive
// RULE8 - three rotation pulses per electrical turn
// RULE9 - direction checked each turn selects drive mode
// RULE10 - reverse rotation: square drive, zero lead
// RULE11 - below threshold always square drive
// RULE12 - overcurrent off, released each carrier cycle
// RULE13 - external reset high holds outputs off
// RULE14 - all halls equal: off, retry each carrier
// RULE15 - no switch to sine drive means lock
// RULE16 - lock detect and off time equal, 1024 ticks
// RULE17 - auto restart alternates on and off
// RULE18 - latched lock cleared by supply or speed
// RULE19 - supply out of range disables outputs
// RULE20 - count time between successive hall edges
// RULE21 - 32 items per interval, step is 1/32
// RULE22 - no edge: keep stepping at same period
// RULE23 - hall edge realigns wave immediately
// RULE24 - control inputs pass a two-stage synchroniser; the code syncs only halls, direction, ext reset and lock select
// RULE25 - phase high while sample exceeds carrier
`ifndef BLDC_DEFS_VH
`define BLDC_DEFS_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INTERVAL 8'h08
`define CTRL_RESET 32'h0000_0001
`define CTRL_DRIVE_EN 0
`define ST_SINE 0
`define ST_LOCK 1
`define ST_OVERCUR 2
`define ST_HALL_FAULT 3
`define ST_DIR_CCW 4
`define ST_SECTOR_LSB 5
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define CARRIER_TOP 7'h7D
`define SLOW_LIMIT 335872
`define STEPS_SHIFT 5
`define LOCK_MS 500
`define LOCK_TICKS 1024
`define LOCK_OSC_CYC (`CLK_MHZ * 1000 * `LOCK_MS / `LOCK_TICKS)
`define SPEED_LOW 8'h1A
`define HALF_WAVE 9'h060
`define FULL_WAVE 9'h0C0
`endif

// File: rtl/bldc_sine_drive.v
// three-phase sine / square commutation logic with protections
// assumes analogue front ends are already digitised and synchronous
// to I_REF_CLK; APB runs on the same clock
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "bldc_defs.vh"
module bldc_sine_drive #(
	parameter SLOW_LIMIT = `SLOW_LIMIT,
	parameter LOCK_OSC_CYC = `LOCK_OSC_CYC,
	parameter SPEED_LOW = `SPEED_LOW
) (
	input wire I_REF_CLK,
	input wire I_RESETN,
	input wire I_HALL_PHASE_U,
	input wire I_HALL_PHASE_V,
	input wire I_HALL_PHASE_W,
	input wire I_DIRECTION_SELECT,
	input wire I_EXT_RESET,
	input wire I_LOCK_RESTART_SELECT,
	input wire [7:0] I_SPEED_COMMAND_LEVEL,
	input wire [4:0] I_LEAD_ANGLE_INPUT,
	input wire I_CURRENT_SENSE_INPUT,
	input wire I_MOTOR_SUPPLY_OK,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	output reg O_PHASE_U_HI,
	output reg O_PHASE_U_LO,
	output reg O_PHASE_V_HI,
	output reg O_PHASE_V_LO,
	output reg O_PHASE_W_HI,
	output reg O_PHASE_W_LO,
	output reg O_ROTATION_PULSE_OUT
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	reg [5:0] sync1; // first stage, read only by sync2
	reg [5:0] sync2; // settled copies
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end else begin
			sync1 <= {I_LOCK_RESTART_SELECT, I_EXT_RESET,
				I_DIRECTION_SELECT, I_HALL_PHASE_U,
				I_HALL_PHASE_V, I_HALL_PHASE_W}; // [RULE24]
			sync2 <= sync1;
		end
	end
	wire [2:0] hall = sync2[2:0]; // {u,v,w}
	wire dir_ccw = sync2[3];
	wire ext_off = sync2[4];
	wire lock_auto = sync2[5];
	reg [2:0] hall_d; // previous hall state for edge finding
	wire hall_bad = (hall == 3'h0) || (hall == 3'h7);
	wire prev_bad = (hall_d == 3'h0) || (hall_d == 3'h7);
	// a step into or out of an illegal code is no 60 degree boundary;
	// this also hides the false edge after reset, when the cleared
	// synchroniser shows all zeros
	wire hall_edge = (hall != hall_d) && !hall_bad && !prev_bad;

	// map a hall pattern to a 60 degree sector
	function [2:0] sector_of;
		input [2:0] h;
		begin
			case (h)
			3'h4: sector_of = 3'h0;
			3'h6: sector_of = 3'h1;
			3'h2: sector_of = 3'h2;
			3'h3: sector_of = 3'h3;
			3'h1: sector_of = 3'h4;
			3'h5: sector_of = 3'h5;
			default: sector_of = 3'h0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// triangle carrier
	// ------------------------------------------------------------
	reg [6:0] carrier; // 0..125 up then 125..0 down
	reg carrier_up;
	wire carrier_start = !carrier_up && (carrier == 7'h00);
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			carrier <= 7'h00;
			carrier_up <= 1'b1;
		end else if (carrier_up) begin
			// each end value is held twice: 2 x 126 = 252 clocks
			if (carrier == `CARRIER_TOP)
				carrier_up <= 1'b0; // [RULE5]
			else
				carrier <= carrier + 7'h01;
		end else begin
			if (carrier == 7'h00)
				carrier_up <= 1'b1; // [RULE5]
			else
				carrier <= carrier - 7'h01;
		end
	end

	// ------------------------------------------------------------
	// interval measurement and waveform stepping
	// ------------------------------------------------------------
	reg [19:0] run_cnt; // clocks since the last hall edge
	reg [19:0] interval; // last full 60 degree interval
	reg [14:0] step_cnt; // clocks inside the current item
	reg [4:0] step; // item index within the interval
	reg [2:0] sector; // estimated sector, may run ahead of halls
	reg [2:0] edges; // edges seen in the current turn
	reg dir_now; // direction of the latest edge, 1 = ccw
	reg dir_meas; // direction checked once per turn
	wire [19:0] slow_lim = SLOW_LIMIT[19:0];
	wire fast = (interval < slow_lim) && (run_cnt < slow_lim);
	wire [14:0] step_len = (interval[19:5] == 15'h0000) ?
		15'h0001 : interval[19:5];
	wire [2:0] hsec = sector_of(hall);
	wire [2:0] psec = sector_of(hall_d);
	wire [2:0] psec_up = (psec == 3'h5) ? 3'h0 : psec + 3'h1;
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			hall_d <= 3'h0;
			run_cnt <= 20'h0_0000;
			interval <= 20'hF_FFFF;
			step_cnt <= 15'h0000;
			step <= 5'h00;
			sector <= 3'h0;
			edges <= 3'h0;
			dir_now <= 1'b0;
			dir_meas <= 1'b0;
			O_ROTATION_PULSE_OUT <= 1'b0;
		end else begin
			hall_d <= hall;
			// parity of the halls toggles on each of 6 edges
			O_ROTATION_PULSE_OUT <= ^hall; // [RULE8]
			if (hall_edge) begin
				interval <= run_cnt; // [RULE20]
				// the edge clock itself is the first of the interval
				run_cnt <= 20'h0_0001;
				step_cnt <= 15'h0000;
				step <= 5'h00; // [RULE23]
				sector <= hsec; // [RULE23]
				dir_now <= (hsec != psec_up);
				if (edges == 3'h5) begin
					edges <= 3'h0;
					dir_meas <= (hsec != psec_up); // [RULE9]
				end else begin
					edges <= edges + 3'h1;
				end
			end else begin
				if (run_cnt != 20'hF_FFFF)
					run_cnt <= run_cnt + 20'h0_0001;
				if (step_cnt + 15'h0001 >= step_len) begin
					// item time is 1/32 of the last interval
					step_cnt <= 15'h0000;
					step <= step + 5'h01; // [RULE21]
					if (step == 5'h1F) begin
						// no edge yet: carry on into the next
						// interval at the same pace
						if (dir_ccw)
							sector <= (sector == 3'h0) ?
								3'h5 : sector - 3'h1; // [RULE22]
						else
							sector <= (sector == 3'h5) ?
								3'h0 : sector + 3'h1; // [RULE22]
					end
				end else begin
					step_cnt <= step_cnt + 15'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------
	// reverse rotation or slow running forces square drive
	wire dir_match = (dir_meas == dir_ccw) && (dir_now == dir_ccw);
	wire sine_mode = fast && dir_match; // [RULE1] [RULE9] [RULE11]
	// lead counted in 1.875 degree items, input LSB dropped: one item per two input steps
	wire [8:0] lead = sine_mode ?
		{5'h00, I_LEAD_ANGLE_INPUT[4:1]} : 9'h000; // [RULE6] [RULE7]
		// zero lead when reversed [RULE10]

	// reduce 0..575 into one electrical turn
	function [8:0] wrap;
		input [9:0] a;
		begin
			if (a >= {1'b0, `FULL_WAVE} + {1'b0, `FULL_WAVE})
				wrap = a[8:0] - `FULL_WAVE - `FULL_WAVE;
			else if (a >= {1'b0, `FULL_WAVE})
				wrap = a[8:0] - `FULL_WAVE;
			else
				wrap = a[8:0];
		end
	endfunction

	wire [8:0] base = {1'b0, sector, 5'h00};
	wire [8:0] fwd = {4'h0, step} + lead;
	wire [9:0] raw = dir_ccw ?
		{1'b0, base} + 10'h0E0 - {1'b0, fwd} :
		{1'b0, base} + {1'b0, fwd};
	wire [8:0] ang_u = wrap(raw); // [RULE2]
	wire [8:0] ang_v = wrap({1'b0, ang_u} + 10'h080);
	wire [8:0] ang_w = wrap({1'b0, ang_u} + 10'h040);

	// parabolic half sine, amplitude set by the speed command
	function [7:0] sample;
		input [8:0] a;
		input [7:0] spd;
		reg [8:0] x;
		reg [22:0] p;
		reg [15:0] m;
		begin
			x = (a < `HALF_WAVE) ? a : a - `HALF_WAVE;
			p = {14'h0000, x} * ({14'h0000, `HALF_WAVE - x})
				* 23'h00_0071;
			m = p[17:10] * spd; // [RULE4]
			// full command equals the reference level: 100 %
			if (a < `HALF_WAVE)
				sample = 8'h80 + {1'b0, m[15:9]};
			else
				sample = 8'h80 - {1'b0, m[15:9]};
		end
	endfunction

	// square drive: 2'b10 high side, 2'b01 low side, 2'b00 floating
	function [1:0] square;
		input [8:0] a;
		begin
			if (a >= 9'h010 && a < 9'h050)
				square = 2'b10;
			else if (a >= 9'h070 && a < 9'h0B0)
				square = 2'b01;
			else
				square = 2'b00;
		end
	endfunction

	// ------------------------------------------------------------
	// protections
	// ------------------------------------------------------------
	reg overcur; // latched trip, freed at each carrier start
	reg hall_fault; // held until a carrier start sees good halls
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			overcur <= 1'b0;
			hall_fault <= 1'b0;
		end else begin
			// a trip in the release cycle still wins
			if (I_CURRENT_SENSE_INPUT)
				overcur <= 1'b1; // [RULE12]
			else if (carrier_start)
				overcur <= 1'b0; // [RULE12]
			if (hall_bad)
				hall_fault <= 1'b1; // [RULE14]
			else if (carrier_start)
				hall_fault <= 1'b0; // [RULE14]
		end
	end

	// lock timer ticks at the capacitor oscillator pace
	localparam LK_RUN = 2'h0;
	localparam LK_OFF = 2'h1;
	localparam LK_LATCH = 2'h2;
	reg [1:0] lk_state;
	reg [16:0] osc_cnt; // clocks per oscillator period
	reg [10:0] tick_cnt; // oscillator periods counted
	wire speed_low = (I_SPEED_COMMAND_LEVEL <= SPEED_LOW[7:0]);
	wire osc_tick = (osc_cnt + 17'h0_0001 >= LOCK_OSC_CYC[16:0]);
	wire lock_done = osc_tick &&
		(tick_cnt == `LOCK_TICKS - 11'h001); // [RULE16]
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			lk_state <= LK_RUN;
			osc_cnt <= 17'h0_0000;
			tick_cnt <= 11'h000;
		end else begin
			osc_cnt <= osc_tick ? 17'h0_0000 : osc_cnt + 17'h0_0001;
			if (osc_tick)
				tick_cnt <= tick_cnt + 11'h001;
			case (lk_state)
			LK_RUN: begin
				if (sine_mode || speed_low) begin
					// reaching sine drive stops the watch
					osc_cnt <= 17'h0_0000;
					tick_cnt <= 11'h000; // [RULE17]
				end else if (lock_done) begin
					tick_cnt <= 11'h000;
					// stuck in square drive: treat as locked
					lk_state <= lock_auto ?
						LK_OFF : LK_LATCH; // [RULE15]
				end
			end
			LK_OFF: begin
				if (lock_done) begin
					tick_cnt <= 11'h000;
					lk_state <= LK_RUN; // [RULE17]
				end
			end
			LK_LATCH: begin
				// only a supply dip or a stop command frees it
				// restart the watch from zero, else a stale count
				// would lock again at once after a supply dip
				if (speed_low || !I_MOTOR_SUPPLY_OK) begin
					osc_cnt <= 17'h0_0000;
					tick_cnt <= 11'h000;
					lk_state <= LK_RUN; // [RULE18]
				end
			end
			default: lk_state <= LK_RUN;
			endcase
		end
	end
	wire locked = (lk_state != LK_RUN);

	// ------------------------------------------------------------
	// register file over APB
	// ------------------------------------------------------------
	reg [31:0] ctrl; // bit0 lets software gate the drive
	wire bus_hit = (I_PADDR == `REG_CTRL) ||
		(I_PADDR == `REG_STATUS) || (I_PADDR == `REG_INTERVAL);
	assign O_PREADY = 1'b1; // zero wait states
	assign O_PSLVERR = I_PSEL && I_PENABLE && !bus_hit;
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ctrl <= `CTRL_RESET;
		end else if (I_PSEL && I_PENABLE && I_PWRITE &&
			(I_PADDR == `REG_CTRL)) begin
			ctrl <= {31'h0000_0000, I_PWDATA[`CTRL_DRIVE_EN]};
		end
	end
	reg [31:0] rd_mux; // word selected by the current address
	// read word chosen from the address, unmapped reads as zero
	always @* begin
		case (I_PADDR)
		`REG_CTRL: rd_mux = ctrl;
		`REG_STATUS: rd_mux = {24'h00_0000, sector, dir_meas,
			hall_fault, overcur, locked, sine_mode};
		`REG_INTERVAL: rd_mux = {12'h000, interval};
		default: rd_mux = 32'h0000_0000;
		endcase
	end
	// read data captured at the setup edge so it stands from a
	// flip-flop through the access phase; status is one clock old
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE) begin
			O_PRDATA <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	// every off condition leaves both switches of each phase open
	wire drive_off = speed_low || ext_off || overcur ||
		hall_fault || locked || !I_MOTOR_SUPPLY_OK ||
		!ctrl[`CTRL_DRIVE_EN]; // [RULE3] [RULE13] [RULE19]
	wire [7:0] car2 = {carrier, 1'b0};
	wire pwm_sq = (I_SPEED_COMMAND_LEVEL > car2);
	wire pu = sample(ang_u, I_SPEED_COMMAND_LEVEL) > car2;
	wire pv = sample(ang_v, I_SPEED_COMMAND_LEVEL) > car2;
	wire pw = sample(ang_w, I_SPEED_COMMAND_LEVEL) > car2;
	wire [1:0] su = square(ang_u);
	wire [1:0] sv = square(ang_v);
	wire [1:0] sw = square(ang_w);
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PHASE_U_HI <= 1'b0;
			O_PHASE_U_LO <= 1'b0;
			O_PHASE_V_HI <= 1'b0;
			O_PHASE_V_LO <= 1'b0;
			O_PHASE_W_HI <= 1'b0;
			O_PHASE_W_LO <= 1'b0;
		end else if (drive_off) begin
			O_PHASE_U_HI <= 1'b0; // [RULE13]
			O_PHASE_U_LO <= 1'b0;
			O_PHASE_V_HI <= 1'b0;
			O_PHASE_V_LO <= 1'b0;
			O_PHASE_W_HI <= 1'b0;
			O_PHASE_W_LO <= 1'b0;
		end else if (sine_mode) begin
			// complementary halves of each bridge leg
			O_PHASE_U_HI <= pu; // [RULE25]
			O_PHASE_U_LO <= !pu;
			O_PHASE_V_HI <= pv; // [RULE25]
			O_PHASE_V_LO <= !pv;
			O_PHASE_W_HI <= pw; // [RULE25]
			O_PHASE_W_LO <= !pw;
		end else begin
			// 120 degree blocks, high side chopped by speed
			O_PHASE_U_HI <= su[1] && pwm_sq; // [RULE1]
			O_PHASE_U_LO <= su[0];
			O_PHASE_V_HI <= sv[1] && pwm_sq;
			O_PHASE_V_LO <= sv[0];
			O_PHASE_W_HI <= sw[1] && pwm_sq;
			O_PHASE_W_LO <= sw[0];
		end
	end
endmodule // bldc_sine_drive

// File: dv/bldc_sine_drive_properties.sv
// port-level checks of the commutation block, bound into its top
// assumes one clock and the block's async active-low reset
`timescale 1ns/1ps
module bldc_sine_drive_properties #(
	parameter SPEED_LOW = 8'h1A
) (
	input wire I_REF_CLK,
	input wire I_RESETN,
	input wire I_HALL_PHASE_U,
	input wire I_HALL_PHASE_V,
	input wire I_HALL_PHASE_W,
	input wire I_EXT_RESET,
	input wire [7:0] I_SPEED_COMMAND_LEVEL,
	input wire I_CURRENT_SENSE_INPUT,
	input wire I_MOTOR_SUPPLY_OK,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire [7:0] I_PADDR,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire O_PHASE_U_HI,
	input wire O_PHASE_U_LO,
	input wire O_PHASE_V_HI,
	input wire O_PHASE_V_LO,
	input wire O_PHASE_W_HI,
	input wire O_PHASE_W_LO,
	input wire O_ROTATION_PULSE_OUT
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	wire [5:0] ph = {O_PHASE_U_HI, O_PHASE_U_LO, O_PHASE_V_HI,
		O_PHASE_V_LO, O_PHASE_W_HI, O_PHASE_W_LO}; // bridge enables
	wire all_off = (ph == 6'h00); // every switch open
	wire hall_x = I_HALL_PHASE_U ^ I_HALL_PHASE_V ^ I_HALL_PHASE_W;
	// all halls equal is no legal rotor position
	wire hall_bad = (I_HALL_PHASE_U == I_HALL_PHASE_V) &&
		(I_HALL_PHASE_V == I_HALL_PHASE_W);
	wire apb_acc = I_PSEL && I_PENABLE; // access phase
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);
	// hold lengths leave room for two sync flops and the output flop
	sequence s_speed_low;
		(I_SPEED_COMMAND_LEVEL <= SPEED_LOW) [*3];
	endsequence
	sequence s_ext_high;
		I_EXT_RESET [*5];
	endsequence
	sequence s_halls_still;
		$stable(hall_x) [*5];
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_speed_off: assert property (s_speed_low |-> all_off)
		else $error("outputs on with low speed command");
	chk_ext_off: assert property (s_ext_high |-> all_off)
		else $error("outputs on during external reset");
	chk_supply_off: assert property (!I_MOTOR_SUPPLY_OK [*4] |-> all_off)
		else $error("outputs on with supply out of range");
	chk_overcur_off: assert property (I_CURRENT_SENSE_INPUT [*4] |-> all_off)
		else $error("outputs on during overcurrent");
	chk_hall_fault: assert property (hall_bad [*5] |-> all_off)
		else $error("outputs on with invalid hall code");
	chk_pulse_xor: assert property (s_halls_still |->
		O_ROTATION_PULSE_OUT == hall_x)
		else $error("rotation pulse does not follow halls");
	chk_apb_ready: assert property (apb_acc |-> O_PREADY)
		else $error("ready low in access phase");
	chk_unmapped_err: assert property (apb_acc && I_PADDR > 8'h08 |->
		O_PSLVERR && O_PRDATA == 32'h0000_0000)
		else $error("unmapped access not refused");
	chk_no_shoot: assert property (!(O_PHASE_U_HI && O_PHASE_U_LO) &&
		!(O_PHASE_V_HI && O_PHASE_V_LO) && !(O_PHASE_W_HI && O_PHASE_W_LO))
		else $error("both switches of one leg on");
endmodule // bldc_sine_drive_properties
bind bldc_sine_drive bldc_sine_drive_properties #(
	.SPEED_LOW(SPEED_LOW)
) u_bldc_sine_drive_properties (
	.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
	.I_HALL_PHASE_U(I_HALL_PHASE_U), .I_HALL_PHASE_V(I_HALL_PHASE_V),
	.I_HALL_PHASE_W(I_HALL_PHASE_W), .I_EXT_RESET(I_EXT_RESET),
	.I_SPEED_COMMAND_LEVEL(I_SPEED_COMMAND_LEVEL),
	.I_CURRENT_SENSE_INPUT(I_CURRENT_SENSE_INPUT),
	.I_MOTOR_SUPPLY_OK(I_MOTOR_SUPPLY_OK), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.O_PHASE_U_HI(O_PHASE_U_HI), .O_PHASE_U_LO(O_PHASE_U_LO),
	.O_PHASE_V_HI(O_PHASE_V_HI), .O_PHASE_V_LO(O_PHASE_V_LO),
	.O_PHASE_W_HI(O_PHASE_W_HI), .O_PHASE_W_LO(O_PHASE_W_LO),
	.O_ROTATION_PULSE_OUT(O_ROTATION_PULSE_OUT)
);

// File: dv/hall_model.sv
// hall sensor source standing in for the spinning rotor
// assumes it shares the device clock; halls are always driven levels
`timescale 1ns/1ps
module hall_model (
	input wire i_clk,
	input wire i_run,
	input wire i_ccw,
	input wire i_fault,
	input wire [15:0] i_period,
	output wire [2:0] o_hall
);
	reg [2:0] sector = 3'h0; // rotor sector 0..5
	reg [15:0] cnt = 16'h0000; // clocks spent in sector
	// cw codes {u,v,w}: 100,110,010,011,001,101
	wire [17:0] seq = 18'h2_64CD;
	// one edge per period, so the interval seen equals i_period
	always @(posedge i_clk) begin
		if (i_run && cnt >= i_period - 16'h0001) begin
			cnt <= 16'h0000;
			if (i_ccw)
				sector <= (sector == 3'h0) ? 3'h5 : sector - 3'h1;
			else
				sector <= (sector == 3'h5) ? 3'h0 : sector + 3'h1;
		end else if (i_run) begin
			cnt <= cnt + 16'h0001;
		end
	end
	// a broken sensor shows all ones
	assign o_hall = i_fault ? 3'h7 : seq[17 - 3 * sector -: 3];
endmodule // hall_model

// File: dv/tb_top.sv
// self-checking bench: apb tasks plus hall-driven motor scenarios
// assumes the block with short slow and lock parameters, 200 MHz
`timescale 1ns/1ps
module tb_top;
	reg clk = 1'b0; // 200 MHz
	reg rst_n = 1'b0; // held low 16 cycles
	reg ext = 1'b0, lsel = 1'b0, dir = 1'b0, oc = 1'b0, sup = 1'b1;
	reg run = 1'b0, ccw = 1'b0, fault = 1'b0; // hall model controls
	reg psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	reg [7:0] spd = 8'hFF, paddr = 8'h00;
	reg [4:0] lead = 5'h1F; // full lead, only felt in sine drive
	reg [31:0] pwdata = 32'h0000_0000, rd;
	reg [15:0] per = 16'h012C; // 300 clocks a sector
	reg er, p_last;
	wire [2:0] hall;
	wire [31:0] prdata;
	wire pready, pslverr, pulse;
	wire [5:0] ph; // u_hi,u_lo,v_hi,v_lo,w_hi,w_lo
	integer errors = 0, total_checks = 0, cyc = 0, i, k, off_run, max_off;
	always #2.5 clk = ~clk;
	hall_model u_hall_model (.i_clk(clk), .i_run(run), .i_ccw(ccw),
		.i_fault(fault), .i_period(per), .o_hall(hall));
	bldc_sine_drive #(.SLOW_LIMIT(2000), .LOCK_OSC_CYC(4),
		.SPEED_LOW(8'h1A)) u_bldc_sine_drive (
		.I_REF_CLK(clk), .I_RESETN(rst_n), .I_HALL_PHASE_U(hall[2]),
		.I_HALL_PHASE_V(hall[1]), .I_HALL_PHASE_W(hall[0]),
		.I_DIRECTION_SELECT(dir), .I_EXT_RESET(ext),
		.I_LOCK_RESTART_SELECT(lsel), .I_SPEED_COMMAND_LEVEL(spd),
		.I_LEAD_ANGLE_INPUT(lead), .I_CURRENT_SENSE_INPUT(oc),
		.I_MOTOR_SUPPLY_OK(sup), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_PHASE_U_HI(ph[5]), .O_PHASE_U_LO(ph[4]), .O_PHASE_V_HI(ph[3]),
		.O_PHASE_V_LO(ph[2]), .O_PHASE_W_HI(ph[1]), .O_PHASE_W_LO(ph[0]),
		.O_ROTATION_PULSE_OUT(pulse));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task final_report;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task check(input string nm, input logic [31:0] seen, exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			// wait for ready; only the bench timeout ends a hang
			while (pready !== 1'b1)
				@(posedge clk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		begin
			apb(1'b0, a, 32'h0000_0000);
			check(nm, rd & m, e);
		end
	endtask
	task wait_c(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// timeout and scenarios
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors = errors + 1;
			final_report;
		end
	end
	initial begin
		wait_c(16);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("ctrl", 8'h00, 32'hFFFF_FFFF, 32'h0000_0001);
		rchk("interval", 8'h08, 32'h000F_FFFF, 32'h000F_FFFF);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF); // unmapped write refused
		check("slverr", {31'h0, er}, 32'h0000_0001);
		rchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0000); // drive disabled
		rchk("ctrl", 8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
		check("disabled", {26'h0, ph}, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0001);
		// fast cw spin, selected cw: sine drive from the first hall edge
		run <= 1'b1;
		wait_c(7200);
		rchk("sine", 8'h04, 32'h0000_0011, 32'h0000_0001);
		rchk("interval", 8'h08, 32'h000F_FFFF, 32'h0000_012C);
		// exactly one turn of 1800 clocks holds three rising pulses
		k = 0;
		p_last = pulse;
		for (i = 0; i < 1800; i = i + 1) begin
			@(posedge clk);
			if (pulse === 1'b1 && p_last === 1'b0)
				k = k + 1;
			p_last = pulse;
		end
		check("pulses", k, 32'h0000_0003);
		// overcurrent longer than a carrier, then release at bottom
		oc <= 1'b1;
		wait_c(300);
		rchk("oc_latch", 8'h04, 32'h0000_0004, 32'h0000_0004);
		oc <= 1'b0;
		wait_c(260);
		rchk("oc_free", 8'h04, 32'h0000_0004, 32'h0000_0000);
		// ext reset, bad supply, speed at its low limit; then recover
		for (i = 0; i < 3; i = i + 1) begin
			ext <= (i == 0);
			sup <= (i != 1);
			spd <= (i == 2) ? 8'h1A : 8'hFF;
			wait_c(8);
			check("off", {26'h0, ph}, 32'h0000_0000);
			ext <= 1'b0;
			sup <= 1'b1;
			spd <= 8'hFF;
			wait_c(300);
			check("on", {31'h0, |ph}, 32'h0000_0001);
		end
		// invalid hall code, retried each carrier once it clears
		fault <= 1'b1;
		wait_c(8);
		rchk("hfault", 8'h04, 32'h0000_0008, 32'h0000_0008);
		fault <= 1'b0;
		wait_c(300);
		rchk("hfree", 8'h04, 32'h0000_0008, 32'h0000_0000);
		// rotation against the selection, then selection flipped
		ccw <= 1'b1;
		wait_c(3600);
		rchk("reverse", 8'h04, 32'h0000_0011, 32'h0000_0010);
		dir <= 1'b1;
		wait_c(3600);
		rchk("ccw_sine", 8'h04, 32'h0000_0011, 32'h0000_0011);
		// slow rotation stays in square drive
		per <= 16'h0BB8;
		wait_c(9000);
		rchk("slow", 8'h04, 32'h0000_0001, 32'h0000_0000);
		rchk("slow_int", 8'h08, 32'h000F_FFFF, 32'h0000_0BB8);
		// stalled rotor, latched lock, cleared by speed command
		run <= 1'b0;
		wait_c(9000);
		rchk("lock", 8'h04, 32'h0000_0002, 32'h0000_0002);
		check("lock_off", {26'h0, ph}, 32'h0000_0000);
		spd <= 8'h00;
		wait_c(8);
		spd <= 8'hFF;
		wait_c(4);
		rchk("unlock", 8'h04, 32'h0000_0002, 32'h0000_0000);
		// auto restart: one off stretch as long as the lock time
		lsel <= 1'b1;
		off_run = 0;
		max_off = 0;
		for (i = 0; i < 14000; i = i + 1) begin
			@(posedge clk);
			if (ph === 6'h00) begin
				off_run = off_run + 1;
			end else begin
				if (off_run > max_off)
					max_off = off_run;
				off_run = 0;
			end
		end
		check("auto_off", max_off >= 4000 && max_off <= 4200, 1);
		final_report;
	end
endmodule // tb_top
